// *** design/tclr_regs.sv ***
// cache lock operation, status, configuration and identification registers
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none


`include "tclr_cfg.svh"

module tclr_regs #(
	parameter logic [3:0] EVT_IDX_BITS = 4'h6,
	parameter logic [3:0] DEV_IDX_BITS = 4'h5,
	parameter logic [3:0] COL_IDX_BITS = 4'h4,
	parameter logic       CACHE_ECC    = 1'b1,
	parameter logic       LOCK_SUPPORT = 1'b1,
	parameter logic       MSI64_EN     = 1'b0,
	parameter logic [3:0] TARGET_BITS  = 4'hd,
	parameter logic [3:0] CREDITS      = 4'h8,
	parameter logic [3:0] ARCH_VERSION = 4'h1, // value arbitrary
	parameter logic [2:0] MFR_CODE_HI  = 3'h2  // value arbitrary
) (
	input  wire logic                i_clk,
	input  wire logic                i_reset,
	input  wire logic [7:0]          i_addr,
	input  wire logic [31:0]         i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic      [31:0]         o_rdata,
	input  wire logic [7:0]          i_block_identifier_tieoff,
	output logic                     o_eng_req,
	output tclr_pkg::tclr_req_t      o_eng_cmd,
	input  wire logic                i_eng_done,
	input  wire tclr_pkg::tclr_resp_t i_eng_resp
);
	import tclr_pkg::*;

	// ============================================================
	// tie-off synchroniser
	// ============================================================
	logic [7:0] id_meta_r;
	logic [7:0] id_sync_r;

	// the tie-off is a pin, so two flops before anything reads it
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			id_meta_r <= 8'h00;
			id_sync_r <= 8'h00;
		end else begin
			id_meta_r <= i_block_identifier_tieoff;
			id_sync_r <= id_meta_r;
		end
	end

	// ============================================================
	// operation register
	// ============================================================
	tclr_req_t   op_r;
	tclr_state_t state_r;
	logic        wr_lo;
	logic        wr_hi;
	logic [3:0]  wr_type;
	logic        type_ok;
	logic [63:0] wr_w64;

	assign wr_lo   = i_wr && (i_addr == `TCLR_OFS_OP_LO) && (state_r == TCLR_IDLE);
	assign wr_hi   = i_wr && (i_addr == `TCLR_OFS_OP_HI) && (state_r == TCLR_IDLE);
	assign wr_w64  = {i_wdata, i_wdata};
	assign wr_type = wr_w64[`TCLR_OP_TYPE];

	// only six codes start work; the rest are reserved
	always_comb begin
		unique case (wr_type)
			TCLR_OP_TRACK, TCLR_OP_TRIAL, TCLR_OP_LOCK,
			TCLR_OP_UNLOCK, TCLR_OP_ABORT, TCLR_OP_UNL_ALL: type_ok = 1'b1;
			default: type_ok = 1'b0;
		endcase
	end

	// low word loads the event number, high word loads type and device and
	// launches if the code is valid; writes while busy are dropped so a running request is stable
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			op_r <= '0;
		end else begin
			if (wr_lo) begin
				op_r.evt <= wr_w64[`TCLR_OP_EVT];
			end
			if (wr_hi) begin
				op_r.op  <= wr_type;
				op_r.dev <= wr_w64[`TCLR_OP_DEV];
			end
		end
	end

	// ============================================================
	// request sequencer
	// ============================================================
	logic cmp_r;
	logic pass_r;
	logic prog_r;
	logic start;
	logic is_result_op;

	assign start        = wr_hi && type_ok;
	assign is_result_op = (op_r.op == TCLR_OP_TRIAL) || (op_r.op == TCLR_OP_LOCK);

	// idle until a valid launch, wait until the engine answers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= TCLR_IDLE;
		end else begin
			unique case (state_r)
				TCLR_IDLE: begin
					if (start) begin
						state_r <= TCLR_WAIT;
					end
				end
				TCLR_WAIT: begin
					if (i_eng_done) begin
						state_r <= TCLR_IDLE;
					end
				end
			endcase
		end
	end

	// one-cycle request to the engine with the full command
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_eng_req <= 1'b0;
			o_eng_cmd <= '0;
		end else begin
			o_eng_req <= start;
			if (start) begin
				o_eng_cmd.op  <= wr_type;
				o_eng_cmd.dev <= wr_w64[`TCLR_OP_DEV];
				o_eng_cmd.evt <= op_r.evt;
			end
		end
	end

	// progress flags; a reserved code finishes at once as a failure
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cmp_r  <= 1'b0;
			pass_r <= 1'b0;
			prog_r <= 1'b0;
		end else if (start) begin
			cmp_r  <= 1'b0;
			pass_r <= 1'b0;
			prog_r <= 1'b1;
		end else if (wr_hi) begin
			cmp_r  <= 1'b1;
			pass_r <= 1'b0;
			prog_r <= 1'b0;
		end else if (prog_r && i_eng_done) begin
			cmp_r  <= 1'b1;
			pass_r <= i_eng_resp.pass;
			prog_r <= 1'b0;
		end
	end

	// ============================================================
	// result fields
	// ============================================================
	logic        locked_r;
	logic [12:0] tgt_r;
	logic [15:0] pid_r;

	// results only carry meaning for trial and lock, so other ops clear them
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			locked_r <= 1'b0;
			tgt_r    <= 13'h0000;
			pid_r    <= 16'h0000;
		end else if (start) begin
			locked_r <= 1'b0;
			tgt_r    <= 13'h0000;
			pid_r    <= 16'h0000;
		end else if (prog_r && i_eng_done && is_result_op) begin
			locked_r <= i_eng_resp.locked;
			tgt_r    <= i_eng_resp.target;
			pid_r    <= i_eng_resp.physical_interrupt_number;
		end
	end

	// ============================================================
	// read path
	// ============================================================
	logic [63:0] op_w64;
	logic [63:0] st_w64;
	logic [31:0] cfg_w32;
	logic [31:0] pid_w32;
	logic [31:0] rd_nxt;

	// reserved fields stay zero by construction
	always_comb begin
		op_w64                 = `TCLR_RST_W64;
		op_w64[`TCLR_OP_TYPE]  = op_r.op;
		op_w64[`TCLR_OP_DEV]   = op_r.dev;
		op_w64[`TCLR_OP_EVT]   = op_r.evt;
		st_w64                 = `TCLR_RST_W64;
		st_w64[`TCLR_ST_CMP]    = cmp_r;
		st_w64[`TCLR_ST_PASS]   = pass_r;
		st_w64[`TCLR_ST_PROG]   = prog_r;
		st_w64[`TCLR_ST_LOCKED] = locked_r;
		st_w64[`TCLR_ST_TGT]    = tgt_r;
		st_w64[`TCLR_ST_PID]    = pid_r;
	end

	// build constants and the identifier tie-off
	always_comb begin
		cfg_w32                    = `TCLR_RST_W32;
		cfg_w32[`TCLR_CFG_EVT_IDX] = EVT_IDX_BITS;
		cfg_w32[`TCLR_CFG_DEV_IDX] = DEV_IDX_BITS;
		cfg_w32[`TCLR_CFG_COL_IDX] = COL_IDX_BITS;
		cfg_w32[`TCLR_CFG_ECC]     = CACHE_ECC;
		cfg_w32[`TCLR_CFG_LOCK]    = LOCK_SUPPORT;
		cfg_w32[`TCLR_CFG_MSI64]   = MSI64_EN;
		cfg_w32[`TCLR_CFG_TGT]     = TARGET_BITS;
		cfg_w32[`TCLR_CFG_CRED]    = CREDITS - 4'h1;
		cfg_w32[`TCLR_CFG_ID]      = id_sync_r;
		pid_w32                    = `TCLR_RST_W32;
		pid_w32[`TCLR_PID_ARCH]    = ARCH_VERSION;
		pid_w32[`TCLR_PID_STD]     = 1'b1;
		pid_w32[`TCLR_PID_MFR]     = MFR_CODE_HI;
	end

	// address decode; unmapped addresses read zero
	always_comb begin
		unique case (i_addr)
			`TCLR_OFS_OP_LO: rd_nxt = op_w64[31:0];
			`TCLR_OFS_OP_HI: rd_nxt = op_w64[63:32];
			`TCLR_OFS_ST_LO: rd_nxt = st_w64[31:0];
			`TCLR_OFS_ST_HI: rd_nxt = st_w64[63:32];
			`TCLR_OFS_CFG:   rd_nxt = cfg_w32;
			`TCLR_OFS_PIDR2: rd_nxt = pid_w32;
			default:         rd_nxt = `TCLR_RST_W32;
		endcase
	end

	// data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= `TCLR_RST_W32;
		end else if (i_rd) begin
			o_rdata <= rd_nxt;
		end else begin
			o_rdata <= `TCLR_RST_W32;
		end
	end

	// ============================================================
	// assertions
	// ============================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	start_sets_prog_a: assert property (
		start |=> prog_r && !cmp_r && !pass_r
	) else $error("launch did not enter progress");

	req_follows_a: assert property (
		start |=> o_eng_req && o_eng_cmd.op == $past(wr_type)
	) else $error("engine request missing or wrong code");

	done_sets_cmp_a: assert property (
		prog_r && i_eng_done |=> cmp_r && !prog_r
	) else $error("completion not flagged");

	pass_match_a: assert property (
		prog_r && i_eng_done |=> pass_r == $past(i_eng_resp.pass)
	) else $error("pass flag does not match answer");

	resvd_fail_a: assert property (
		wr_hi && !type_ok |=> cmp_r && !pass_r && !prog_r && !o_eng_req
	) else $error("reserved code not failed");

	prog_hold_a: assert property (
		prog_r && !i_eng_done |=> prog_r
	) else $error("progress dropped before answer");

	result_clear_a: assert property (
		prog_r && i_eng_done && !is_result_op |=> !locked_r && tgt_r == 13'h0000
	) else $error("result fields set for non-result op");

	rdata_idle_a: assert property (
		!i_rd |=> o_rdata == 32'h0000_0000
	) else $error("read data outside its cycle");

	pidr_read_a: assert property (
		i_rd && i_addr == `TCLR_OFS_PIDR2 |=> o_rdata[31:8] == 24'h000000 && o_rdata[3]
	) else $error("identification read wrong");

	cfg_read_a: assert property (
		i_rd && i_addr == `TCLR_OFS_CFG |=> o_rdata[17] == LOCK_SUPPORT && !o_rdata[19]
	) else $error("configuration read wrong");

	eng_pulse_a: assert property (
		o_eng_req |=> !o_eng_req
	) else $error("engine request longer than one cycle");

	prog_state_a: assert property (
		prog_r == (state_r == TCLR_WAIT)
	) else $error("progress flag and sequencer disagree");

	prog_not_cmp_a: assert property (
		prog_r |-> !cmp_r
	) else $error("complete flagged while in progress");

	busy_drop_a: assert property (
		state_r == TCLR_WAIT && i_wr |=> op_r == $past(op_r)
	) else $error("operation register changed while busy");

	cmd_hold_a: assert property (
		!start |=> o_eng_cmd == $past(o_eng_cmd)
	) else $error("engine command changed without launch");

	result_load_a: assert property (
		prog_r && i_eng_done && is_result_op |=> tgt_r == $past(i_eng_resp.target)
			&& pid_r == $past(i_eng_resp.physical_interrupt_number) && locked_r == $past(i_eng_resp.locked)
	) else $error("result fields not loaded from answer");

	st_resvd_a: assert property (
		i_rd && i_addr == `TCLR_OFS_ST_HI |=> o_rdata[28:17] == 12'h000
			&& o_rdata[15:13] == 3'h0
	) else $error("reserved status bits read non-zero");

	st_lo_resvd_a: assert property (
		i_rd && i_addr == `TCLR_OFS_ST_LO |=> o_rdata[31:16] == 16'h0000
	) else $error("reserved status low bits read non-zero");

	op_resvd_a: assert property (
		i_rd && i_addr == `TCLR_OFS_OP_HI |=> o_rdata[27:20] == 8'h00
	) else $error("reserved operation bits read non-zero");

	op_lo_resvd_a: assert property (
		i_rd && i_addr == `TCLR_OFS_OP_LO |=> o_rdata[31:16] == 16'h0000
	) else $error("reserved operation low bits read non-zero");

	cfg_fields_a: assert property (
		i_rd && i_addr == `TCLR_OFS_CFG
			|=> o_rdata[31:20] == {EVT_IDX_BITS, DEV_IDX_BITS, COL_IDX_BITS}
	) else $error("cache index widths read wrong");

	cfg_build_a: assert property (
		i_rd && i_addr == `TCLR_OFS_CFG |=> o_rdata[18] == CACHE_ECC && o_rdata[16] == MSI64_EN
			&& o_rdata[15:12] == TARGET_BITS && o_rdata[11:8] == CREDITS - 4'h1
	) else $error("build parameters read wrong");

	cfg_ident_a: assert property (
		i_rd && i_addr == `TCLR_OFS_CFG |=> o_rdata[7:0] == $past(id_sync_r)
	) else $error("block identifier read wrong");

	pid_fields_a: assert property (
		i_rd && i_addr == `TCLR_OFS_PIDR2 |=> o_rdata[7:4] == ARCH_VERSION
			&& o_rdata[2:0] == MFR_CODE_HI
	) else $error("identification fields read wrong");

	lock_done_c:  cover property (start && wr_type == TCLR_OP_LOCK ##[1:20] prog_r && i_eng_done);
	resvd_op_c:   cover property (wr_hi && !type_ok);
	status_rd_c:  cover property (cmp_r && i_rd && i_addr == `TCLR_OFS_ST_HI);
	busy_wr_c:    cover property (state_r == TCLR_WAIT && i_wr && i_addr == `TCLR_OFS_OP_HI);
	stray_done_c: cover property (!prog_r && i_eng_done);

endmodule

`default_nettype wire

// *** design/tclr_cfg.svh ***
// offsets, field positions and reset values of the cache lock registers
`ifndef TCLR_CFG_SVH
`define TCLR_CFG_SVH

// register word offsets on the 32-bit register port (byte addresses)
`define TCLR_OFS_OP_LO   8'h00
`define TCLR_OFS_OP_HI   8'h04
`define TCLR_OFS_ST_LO   8'h08
`define TCLR_OFS_ST_HI   8'h0c
`define TCLR_OFS_CFG     8'h10
`define TCLR_OFS_PIDR2   8'h14

// operation register fields, 64-bit positions
`define TCLR_OP_TYPE     63:60
`define TCLR_OP_DEV      51:32
`define TCLR_OP_EVT      15:0

// status register fields, 64-bit positions
`define TCLR_ST_CMP      63
`define TCLR_ST_PASS     62
`define TCLR_ST_PROG     61
`define TCLR_ST_LOCKED   48
`define TCLR_ST_TGT      44:32
`define TCLR_ST_PID      15:0

// configuration register fields
`define TCLR_CFG_EVT_IDX 31:28
`define TCLR_CFG_DEV_IDX 27:24
`define TCLR_CFG_COL_IDX 23:20
`define TCLR_CFG_ECC     18
`define TCLR_CFG_LOCK    17
`define TCLR_CFG_MSI64   16
`define TCLR_CFG_TGT     15:12
`define TCLR_CFG_CRED    11:8
`define TCLR_CFG_ID      7:0

// identification register fields
`define TCLR_PID_ARCH    7:4
`define TCLR_PID_STD     3
`define TCLR_PID_MFR     2:0

// reset values
`define TCLR_RST_W64     64'h0000_0000_0000_0000
`define TCLR_RST_W32     32'h0000_0000

`endif

// *** design/tclr_pkg.sv ***
// types shared by the cache lock register bank
package tclr_pkg;

	// operation codes of the operation-type field
	typedef enum logic [3:0] {
		TCLR_OP_TRACK   = 4'h0,
		TCLR_OP_TRIAL   = 4'h1,
		TCLR_OP_LOCK    = 4'h2,
		TCLR_OP_UNLOCK  = 4'h3,
		TCLR_OP_ABORT   = 4'h4,
		TCLR_OP_UNL_ALL = 4'h8
	} tclr_op_t;

	// request handed to the translation engine
	typedef struct packed {
		logic [3:0]  op;
		logic [19:0] dev;
		logic [15:0] evt;
	} tclr_req_t;

	// answer returned by the translation engine
	typedef struct packed {
		logic        pass;
		logic        locked;
		logic [12:0] target;
		logic [15:0] physical_interrupt_number;
	} tclr_resp_t;

	typedef enum logic {
		TCLR_IDLE = 1'b0,
		TCLR_WAIT = 1'b1
	} tclr_state_t;

endpackage

// *** verif/tclr_regs_tb.sv ***
// self-checking testbench for the cache lock register bank
`timescale 1ns/10ps
`default_nettype none
`include "tclr_cfg.svh"

module testbench;
	import tclr_pkg::*;

	// ==========================================================
	// signals and bench state
	logic             i_clk      = 1'b0;
	logic             i_reset    = 1'b1;
	logic [7:0]       i_addr     = 8'h00;
	logic [31:0]      i_wdata    = 32'h0;
	logic             i_wr       = 1'b0;
	logic             i_rd       = 1'b0;
	logic [31:0]      o_rdata;
	logic [7:0]       i_tie      = 8'h00;
	logic             o_eng_req;
	tclr_req_t        o_eng_cmd;
	logic             i_eng_done = 1'b0;
	tclr_resp_t       i_eng_resp = '0;
	int               fails      = 0;
	int               n_tests    = 0;
	int               seed       = 24;
	int               cyc        = 0;
	int               n_req      = 0;
	logic [31:0]      d;

	// ==========================================================
	// device under test, some build values moved off the defaults, the rest keep them
	tclr_regs #(.MSI64_EN(1'b1), .TARGET_BITS(4'hc), .CREDITS(4'h6), .ARCH_VERSION(4'h4),
		.MFR_CODE_HI(3'h5)) tclr_regs_inst (
		.i_clk                     (i_clk),
		.i_reset                   (i_reset),
		.i_addr                    (i_addr),
		.i_wdata                   (i_wdata),
		.i_wr                      (i_wr),
		.i_rd                      (i_rd),
		.o_rdata                   (o_rdata),
		.i_block_identifier_tieoff (i_tie),
		.o_eng_req                 (o_eng_req),
		.o_eng_cmd                 (o_eng_cmd),
		.i_eng_done                (i_eng_done),
		.i_eng_resp                (i_eng_resp)
	);

	// ==========================================================
	// clock, launch counter and hang guard
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	// launches are counted so that ignored writes show up as extra pulses
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_eng_req === 1'b1) begin
			n_req <= n_req + 1;
		end
		if (cyc == 5000) begin
			fails = fails + 1;
			results();
		end
	end

	// ==========================================================
	// checking, expectations and bus tasks
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_eng(input logic [40:0] got, input logic [40:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// result fields are only meaningful for trial and lock
	function automatic logic [31:0] st_hi(input logic [3:0] c, input tclr_resp_t r);
		logic tl;
		tl = (c == 4'h1) || (c == 4'h2);
		return {1'b1, r.pass, 1'b0, 12'h0, tl & r.locked, 3'h0, tl ? r.target : 13'h0};
	endfunction

	function automatic logic [31:0] st_lo(input logic [3:0] c, input tclr_resp_t r);
		return {16'h0, ((c == 4'h1) || (c == 4'h2)) ? r.physical_interrupt_number : 16'h0};
	endfunction

	// a gap cycle between strobes keeps one assignment per signal per step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1 v = o_rdata;
	endtask

	task automatic done(input tclr_resp_t r);
		@(posedge i_clk);
		i_eng_done <= 1'b1;
		i_eng_resp <= r;
		@(posedge i_clk);
		i_eng_done <= 1'b0;
	endtask

	// one operation code end to end, reserved junk in the should-be-zero bits
	task automatic run_op(input logic [3:0] c);
		logic [15:0] evt;
		logic [19:0] dev;
		tclr_resp_t  r;
		logic        ok;
		evt = 16'($random(seed));
		dev = 20'($random(seed));
		r   = 31'($random(seed));
		ok  = (c <= 4'h4) || (c == 4'h8);
		wr(`TCLR_OFS_OP_LO, {16'($random(seed)), evt});
		wr(`TCLR_OFS_OP_HI, {c, 8'($random(seed)), dev});
		#1;
		if (ok) begin
			chk_eng({o_eng_req, o_eng_cmd}, {1'b1, c, dev, evt});
			rd(`TCLR_OFS_ST_HI, d);
			chk_rd(d, 32'h2000_0000);
			wr(`TCLR_OFS_OP_HI, {4'h2, 8'h00, ~dev});
			rd(`TCLR_OFS_OP_HI, d);
			chk_rd(d, {c, 8'h00, dev});
			rd(`TCLR_OFS_OP_LO, d);
			chk_rd(d, {16'h0, evt});
			done(r);
			rd(`TCLR_OFS_ST_HI, d);
			chk_rd(d, st_hi(c, r));
			rd(`TCLR_OFS_ST_LO, d);
			chk_rd(d, st_lo(c, r));
			done(~r);
			rd(`TCLR_OFS_ST_HI, d);
			chk_rd(d, st_hi(c, r));
		end else begin
			rd(`TCLR_OFS_ST_HI, d);
			chk_rd(d & 32'he000_0000, 32'h8000_0000);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		i_tie = 8'($random(seed));
		repeat (20) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(`TCLR_OFS_ST_HI, d);
		chk_rd(d, 32'h0);
		rd(`TCLR_OFS_CFG, d);
		chk_rd(d, {4'h6, 4'h5, 4'h4, 4'h7, 4'hc, 4'h5, i_tie});
		rd(`TCLR_OFS_PIDR2, d);
		chk_rd(d, {24'h0, 4'h4, 1'b1, 3'h5});
		rd(8'h18, d);
		chk_rd(d, 32'h0);
		wr(`TCLR_OFS_CFG, 32'hffff_ffff);
		rd(`TCLR_OFS_CFG, d);
		chk_rd(d, {4'h6, 4'h5, 4'h4, 4'h7, 4'hc, 4'h5, i_tie});
		for (int i = 0; i < 16; i++) begin
			run_op(4'(i));
		end
		chk_rd(32'(n_req), 32'h0000_0006);
		results();
	end
endmodule
`default_nettype wire
